// ---- logic/csp_regs.sv ----
// Core arithmetic/bank state register and peripheral interrupt enables.
// Assumes a single-cycle register port and one-cycle core event pulses.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

// Overview of operation
// R1 - State register mirrored in all four banks
// R2 - Indirect select picks banks 2-3 or 0-1
// R3 - Two direct select bits pick 128-byte bank
// R4 - Watchdog flag: set by reset/clear/sleep, timeout clears
// R5 - Sleep flag: set by reset/clear, sleep clears
// R6 - Zero flag follows zero result
// R7 - Nibble carry from bit 3 for add/sub
// R8 - Carry from bit 7 for add/sub
// R9 - Subtract carries are active-low borrows
// R10 - Subtract adds two's complement of operand
// R11 - Rotate loads carry with shifted-out bit
// R12 - Enable register at offset 8Ch
// R13 - Peripheral gate needed for any peripheral interrupt
// R14 - Bit 6 enables converter interrupt, resets 0
// R15 - Bit 3 enables serial interrupt, resets 0
// R16 - Bits 7,5,4 unimplemented, read zero
// R17 - ALU flags override software write to them
// R18 - Watchdog and sleep flags ignore software writes
// R19 - Bits 2,1,0 enable capture, period, overflow
// R20 - Flags set regardless of enables
// R21 - Request needs flag, enable, both gates
module csp_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic alu_valid,
  input wire csp_pkg::csp_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  output logic [7:0] alu_result,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic [7:0] indirect_ptr,
  input wire logic [6:0] direct_offset,
  output logic [8:0] indirect_addr,
  output logic [8:0] direct_addr,
  input wire logic [7:0] periph_event,
  input wire logic peripheral_irq_gate,
  input wire logic global_irq_gate,
  output logic periph_irq_req,
  output logic [7:0] state_out
);

  logic [7:0] state_reg;
  logic [7:0] state_next;
  logic [7:0] pie_reg;
  logic [7:0] pir_reg;
  logic [7:0] pir_next;
  logic [7:0] rdata_reg;
  logic [7:0] alu_result_reg;
  logic [8:0] indirect_addr_reg;
  logic [8:0] direct_addr_reg;
  logic irq_reg;
  logic hit_state;
  logic hit_pie;
  logic hit_pir;

  csp_alu_if alu_bus ();

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  assign alu_bus.op = alu_op;
  assign alu_bus.a = alu_a;
  assign alu_bus.b = alu_b;
  assign alu_bus.carry_in = state_reg[csp_pkg::C_BIT];

  csp_alu_flags u_alu (
    .alu(alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hit_state = (addr[csp_pkg::BANK_W-1:0] == csp_pkg::STATE_OFFSET); // R1
  assign hit_pie = (addr == csp_pkg::PIE_ADDR); // R12
  assign hit_pir = (addr == csp_pkg::PIR_ADDR);

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (wr_en && hit_state) begin
      state_next[csp_pkg::IND_BIT] = wdata[csp_pkg::IND_BIT];
      state_next[csp_pkg::DIR_HI_BIT] = wdata[csp_pkg::DIR_HI_BIT];
      state_next[csp_pkg::DIR_LO_BIT] = wdata[csp_pkg::DIR_LO_BIT];
      // Watchdog and sleep flags stay untouched here
      if (!(alu_valid && alu_bus.upd_z)) begin // R17 R18
        state_next[csp_pkg::Z_BIT] = wdata[csp_pkg::Z_BIT];
      end
      if (!(alu_valid && alu_bus.upd_nc)) begin // R17
        state_next[csp_pkg::NCARRY_BIT] = wdata[csp_pkg::NCARRY_BIT];
      end
      if (!(alu_valid && alu_bus.upd_c)) begin // R17
        state_next[csp_pkg::C_BIT] = wdata[csp_pkg::C_BIT];
      end
    end
    if (alu_valid) begin
      if (alu_bus.upd_z) begin
        state_next[csp_pkg::Z_BIT] = alu_bus.z; // R6
      end
      if (alu_bus.upd_nc) begin
        state_next[csp_pkg::NCARRY_BIT] = alu_bus.nc; // R7
      end
      if (alu_bus.upd_c) begin
        state_next[csp_pkg::C_BIT] = alu_bus.c; // R8 R11
      end
    end
    if (watchdog_clear_instr) begin
      state_next[csp_pkg::WDX_BIT] = 1'b1; // R4
      state_next[csp_pkg::SLP_BIT] = 1'b1; // R5
    end else if (sleep_instr) begin
      state_next[csp_pkg::WDX_BIT] = 1'b1; // R4
      state_next[csp_pkg::SLP_BIT] = 1'b0; // R5
    end
    if (watchdog_timeout) begin
      state_next[csp_pkg::WDX_BIT] = 1'b0; // R4
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= csp_pkg::STATE_RESET; // R4 R5
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alu_result_reg <= 8'h00;
    end else if (alu_valid) begin
      alu_result_reg <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // Bank address forming
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      indirect_addr_reg <= 9'h000;
      direct_addr_reg <= 9'h000;
    end else begin
      indirect_addr_reg <= {state_reg[csp_pkg::IND_BIT], indirect_ptr}; // R2
      direct_addr_reg <= {state_reg[csp_pkg::DIR_HI_BIT],
                          state_reg[csp_pkg::DIR_LO_BIT], direct_offset}; // R3
    end
  end

  // ----------------------------------------------------------------
  // Peripheral enables and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pie_reg <= csp_pkg::PIE_RESET; // R14 R15
    end else if (wr_en && hit_pie) begin
      pie_reg <= wdata & csp_pkg::PIE_MASK; // R16 R19
    end
  end

  always_comb begin
    pir_next = pir_reg;
    if (wr_en && hit_pir) begin
      pir_next = wdata;
    end
    pir_next = (pir_next | periph_event) & csp_pkg::PIE_MASK; // R20
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pir_reg <= csp_pkg::PIR_RESET;
    end else begin
      pir_reg <= pir_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (|(pir_reg & pie_reg)) && peripheral_irq_gate && global_irq_gate; // R13 R21
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_en && hit_state) begin
      rdata_reg <= state_reg;
    end else if (rd_en && hit_pie) begin
      rdata_reg <= pie_reg; // R16
    end else if (rd_en && hit_pir) begin
      rdata_reg <= pir_reg;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign alu_result = alu_result_reg;
  assign indirect_addr = indirect_addr_reg;
  assign direct_addr = direct_addr_reg;
  assign periph_irq_req = irq_reg;
  assign state_out = state_reg;

endmodule // csp_regs

// ---- logic/csp_pkg.sv ----
// Package of the core state and peripheral enable register bank.
// Assumes an 8-bit core data bus with 9-bit data-memory addresses.
package csp_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int BANK_W = 7;
  localparam logic [BANK_W-1:0] STATE_OFFSET = 7'h03;
  localparam logic [ADDR_W-1:0] PIE_ADDR = 9'h08C;
  localparam logic [ADDR_W-1:0] PIR_ADDR = 9'h00C;

  // ----------------------------------------------------------------
  // State register fields
  // ----------------------------------------------------------------
  localparam int IND_BIT = 7;
  localparam int DIR_HI_BIT = 6;
  localparam int DIR_LO_BIT = 5;
  localparam int WDX_BIT = 4;
  localparam int SLP_BIT = 3;
  localparam int Z_BIT = 2;
  localparam int NCARRY_BIT = 1;
  localparam int C_BIT = 0;
  localparam int NIBBLE_BIT = 4;
  localparam logic [DATA_W-1:0] STATE_RESET = 8'h18;

  // ----------------------------------------------------------------
  // Peripheral enable and flag fields
  // ----------------------------------------------------------------
  localparam int CONV_BIT = 6;
  localparam int SER_BIT = 3;
  localparam int CAP_BIT = 2;
  localparam int PER_BIT = 1;
  localparam int OVF_BIT = 0;
  localparam logic [DATA_W-1:0] PIE_MASK = 8'h4F;
  localparam logic [DATA_W-1:0] PIE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PIR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // ALU operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSP_OP_ADD,
    CSP_OP_SUB,
    CSP_OP_AND,
    CSP_OP_OR,
    CSP_OP_XOR,
    CSP_OP_RLF,
    CSP_OP_RRF,
    CSP_OP_MOVE
  } csp_op_t;

endpackage : csp_pkg

// ---- logic/csp_alu_if.sv ----
// Interface between the register bank and its flag-producing ALU.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/1ps
interface csp_alu_if;
  csp_pkg::csp_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic carry_in;
  logic [7:0] result;
  logic z;
  logic nc;
  logic c;
  logic upd_z;
  logic upd_nc;
  logic upd_c;

  modport bank (output op, a, b, carry_in, input result, z, nc, c, upd_z, upd_nc, upd_c);
  modport alu (input op, a, b, carry_in, output result, z, nc, c, upd_z, upd_nc, upd_c);
endinterface : csp_alu_if

// ---- logic/csp_alu_flags.sv ----
// Combinational ALU producing the result and zero/nibble-carry/carry.
// Assumes the bank drives operands and takes results the same cycle.
`timescale 1ns/1ps
module csp_alu_flags (
  csp_alu_if.alu alu
);

  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] addend;
  logic sub_in;

  // ----------------------------------------------------------------
  // Adder shared by add and subtract
  // ----------------------------------------------------------------
  always_comb begin
    sub_in = (alu.op == csp_pkg::CSP_OP_SUB);
    addend = sub_in ? ~alu.b : alu.b; // R10
    sum = {1'b0, alu.a} + {1'b0, addend} + {8'h00, sub_in}; // R10
    low_sum = {1'b0, alu.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub_in};
  end

  // ----------------------------------------------------------------
  // Result and flags
  // ----------------------------------------------------------------
  always_comb begin
    alu.result = sum[7:0];
    alu.nc = low_sum[csp_pkg::NIBBLE_BIT]; // R7 R9
    alu.c = sum[8]; // R8 R9
    alu.upd_z = 1'b1;
    alu.upd_nc = 1'b0;
    alu.upd_c = 1'b0;
    case (alu.op)
      csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_SUB: begin
        alu.upd_nc = 1'b1;
        alu.upd_c = 1'b1;
      end
      csp_pkg::CSP_OP_AND: alu.result = alu.a & alu.b;
      csp_pkg::CSP_OP_OR: alu.result = alu.a | alu.b;
      csp_pkg::CSP_OP_XOR: alu.result = alu.a ^ alu.b;
      csp_pkg::CSP_OP_RLF: begin
        alu.result = {alu.a[6:0], alu.carry_in};
        alu.c = alu.a[7]; // R11
        alu.upd_z = 1'b0;
        alu.upd_c = 1'b1;
      end
      csp_pkg::CSP_OP_RRF: begin
        alu.result = {alu.carry_in, alu.a[7:1]};
        alu.c = alu.a[0]; // R11
        alu.upd_z = 1'b0;
        alu.upd_c = 1'b1;
      end
      csp_pkg::CSP_OP_MOVE: alu.result = alu.a;
      default: alu.result = sum[7:0];
    endcase
    alu.z = (alu.result == 8'h00); // R6
  end

endmodule // csp_alu_flags

// ---- testbench/csp_regs_props.sv ----
// Concurrent checks on the state and peripheral enable register bank.
// Assumes it is bound to csp_regs and sees only its ports.
`timescale 1ns/1ps
module csp_regs_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic [8:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic alu_valid,
  input wire csp_pkg::csp_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic [7:0] indirect_ptr,
  input wire logic [6:0] direct_offset,
  input wire logic [8:0] indirect_addr,
  input wire logic [8:0] direct_addr,
  input wire logic peripheral_irq_gate,
  input wire logic global_irq_gate,
  input wire logic periph_irq_req,
  input wire logic [7:0] state_out
);
  // ----
  // Checks
  // ----
  wire logic [8:0] sum_w = {1'b0, alu_a} + {1'b0, alu_b};
  wire logic [8:0] dif_w = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_MIRROR: assert property (rd_en && addr[6:0] == 7'h03 |=> rdata == $past(state_out))
    else $error("state read differs from state register");
  AST_IND: assert property (!$past(rst) |-> indirect_addr == {$past(state_out[7]), $past(indirect_ptr)})
    else $error("indirect address wrong");
  AST_DIR: assert property (!$past(rst) |-> direct_addr == {$past(state_out[6:5]), $past(direct_offset)})
    else $error("direct address wrong");
  AST_TIMEOUT: assert property (watchdog_timeout |=> !state_out[4])
    else $error("timeout did not clear watchdog flag");
  AST_SLEEP: assert property (sleep_instr && !watchdog_clear_instr |=>
    !state_out[3] && state_out[4] != $past(watchdog_timeout))
    else $error("sleep flags wrong");
  AST_NOWRITE: assert property (wr_en && addr[6:0] == 7'h03 && !watchdog_clear_instr && !sleep_instr
    && !watchdog_timeout |=> $stable(state_out[4:3]))
    else $error("software changed read-only flags");
  AST_UNIMPL: assert property (rd_en && addr == 9'h08C |=> (rdata & 8'hB0) == 8'h00)
    else $error("unimplemented enable bits read nonzero");
  AST_GATE: assert property (periph_irq_req |-> $past(peripheral_irq_gate) && $past(global_irq_gate))
    else $error("request without both gates");
  AST_ADD: assert property (alu_valid && alu_op == csp_pkg::CSP_OP_ADD |=>
    {state_out[0], alu_result} == $past(sum_w))
    else $error("add carry or result wrong");
  AST_SUB: assert property (alu_valid && alu_op == csp_pkg::CSP_OP_SUB |=>
    {state_out[0], alu_result} == $past(dif_w))
    else $error("subtract borrow or result wrong");
endmodule // csp_regs_props

bind csp_regs csp_regs_props csp_regs_props_inst (
  .clock(clock),
  .rst(rst),
  .addr(addr),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rdata(rdata),
  .alu_valid(alu_valid),
  .alu_op(alu_op),
  .alu_a(alu_a),
  .alu_b(alu_b),
  .alu_result(alu_result),
  .watchdog_clear_instr(watchdog_clear_instr),
  .sleep_instr(sleep_instr),
  .watchdog_timeout(watchdog_timeout),
  .indirect_ptr(indirect_ptr),
  .direct_offset(direct_offset),
  .indirect_addr(indirect_addr),
  .direct_addr(direct_addr),
  .peripheral_irq_gate(peripheral_irq_gate),
  .global_irq_gate(global_irq_gate),
  .periph_irq_req(periph_irq_req),
  .state_out(state_out)
);

// ---- testbench/test_core_status_and_periph_irq_enable.sv ----
// Self-checking bench for the state and peripheral enable register bank.
// Assumes csp_pkg, csp_regs and its checker are compiled first.
`timescale 1ns/1ps
module test_core_status_and_periph_irq_enable;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00, alu_a = 8'h00, alu_b = 8'h00, periph_event = 8'h00;
  logic [7:0] indirect_ptr = 8'h00;
  logic [6:0] direct_offset = 7'h00;
  logic wr_en = 1'b0, rd_en = 1'b0, alu_valid = 1'b0, watchdog_clear_instr = 1'b0;
  logic sleep_instr = 1'b0, watchdog_timeout = 1'b0;
  logic peripheral_irq_gate = 1'b0, global_irq_gate = 1'b0;
  csp_pkg::csp_op_t alu_op = csp_pkg::CSP_OP_ADD;
  logic [7:0] rdata, alu_result, state_out, st, b;
  logic [8:0] indirect_addr, direct_addr;
  logic periph_irq_req;
  logic rd_d = 1'b0, alu_d = 1'b0;
  logic [7:0] rd_q[$], res_q[$];
  int errors = 0, tests_run = 0, seed = 32'h6A4CCDFF;
  int bits[5] = '{6, 3, 2, 1, 0};
  csp_pkg::csp_op_t ops[8] = '{csp_pkg::CSP_OP_ADD, csp_pkg::CSP_OP_SUB,
    csp_pkg::CSP_OP_RLF, csp_pkg::CSP_OP_RRF, csp_pkg::CSP_OP_AND, csp_pkg::CSP_OP_OR,
    csp_pkg::CSP_OP_XOR, csp_pkg::CSP_OP_MOVE};
  always #12.5 clock = ~clock;
  csp_regs csp_regs_inst (
    .clock(clock),
    .rst(rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .alu_valid(alu_valid),
    .alu_op(alu_op),
    .alu_a(alu_a),
    .alu_b(alu_b),
    .alu_result(alu_result),
    .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instr(sleep_instr),
    .watchdog_timeout(watchdog_timeout),
    .indirect_ptr(indirect_ptr),
    .direct_offset(direct_offset),
    .indirect_addr(indirect_addr),
    .direct_addr(direct_addr),
    .periph_event(periph_event),
    .peripheral_irq_gate(peripheral_irq_gate),
    .global_irq_gate(global_irq_gate),
    .periph_irq_req(periph_irq_req),
    .state_out(state_out)
  );
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic drive(input logic [5:0] ctl, input logic [8:0] a, input logic [7:0] d);
    {wr_en, rd_en, alu_valid, watchdog_clear_instr, sleep_instr, watchdog_timeout} <= ctl;
    addr <= a;
    wdata <= d;
    indirect_ptr <= 8'($random(seed));
    direct_offset <= 7'($random(seed));
    @(posedge clock);
  endtask
  task automatic idle();
    drive(6'h00, 9'h000, 8'h00);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    if (a[6:0] == 7'h03) st = {d[7:5], st[4:3], d[2:0]};
    drive(6'h20, a, d);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    drive(6'h10, a, 8'h00);
  endtask
  task automatic ev(input logic [2:0] cst);
    if (cst[2]) st[4:3] = 2'b11;
    else if (cst[1]) st[4:3] = 2'b10;
    if (cst[0]) st[4] = 1'b0;
    drive({3'h0, cst}, 9'h000, 8'h00);
  endtask
  task automatic alu(input csp_pkg::csp_op_t op, input logic [7:0] x, y, input logic w);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] res;
    logic sb;
    sb = (op == csp_pkg::CSP_OP_SUB);
    s = {1'b0, x} + (sb ? {1'b0, ~y} + 9'h001 : {1'b0, y});
    n = {1'b0, x[3:0]} + (sb ? {1'b0, ~y[3:0]} + 5'h01 : {1'b0, y[3:0]});
    case (op)
      csp_pkg::CSP_OP_AND: res = x & y;
      csp_pkg::CSP_OP_OR: res = x | y;
      csp_pkg::CSP_OP_XOR: res = x ^ y;
      csp_pkg::CSP_OP_MOVE: res = x;
      csp_pkg::CSP_OP_RLF: res = {x[6:0], st[0]};
      csp_pkg::CSP_OP_RRF: res = {st[0], x[7:1]};
      default: res = s[7:0];
    endcase
    if (w) st = {3'h0, st[4:3], 3'h0};
    if (op == csp_pkg::CSP_OP_RLF) st[0] = x[7];
    else if (op == csp_pkg::CSP_OP_RRF) st[0] = x[0];
    else if (sb || op == csp_pkg::CSP_OP_ADD) st[2:0] = {s[7:0] == 8'h00, n[4], s[8]};
    else st[2] = (res == 8'h00);
    res_q.push_back(res);
    alu_op <= op;
    alu_a <= x;
    alu_b <= y;
    drive({w, 5'h08}, 9'h103, 8'h00);
  endtask
  task automatic req(input logic e);
    @(negedge clock);
    chk({7'h00, periph_irq_req}, {7'h00, e});
    @(posedge clock);
  endtask
  // ----
  // Monitor and main sequence
  // ----
  always @(posedge clock) begin
    if (rd_d) chk(rdata, rd_q.pop_front());
    if (alu_d) chk(alu_result, res_q.pop_front());
    rd_d <= rd_en;
    alu_d <= alu_valid;
  end
  initial begin
    st = 8'h18;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(9'h003, st);
    rd(9'h083, st);
    rd(9'h103, st);
    rd(9'h183, st);
    rd(9'h08C, 8'h00);
    rd(9'h055, 8'h00);
    wr(9'h08C, 8'hFF);
    rd(9'h08C, 8'h4F);
    wr(9'h083, 8'hE7);
    rd(9'h003, st);
    ev(3'b001);
    wr(9'h003, 8'hFF);
    rd(9'h183, st);
    for (int i = 0; i < 8; i++) begin
      ev(3'(i));
      rd(9'h003, st);
    end
    wr(9'h183, 8'h40);
    alu(csp_pkg::CSP_OP_SUB, 8'h05, 8'h03, 1'b0);
    rd(9'h003, st);
    alu(csp_pkg::CSP_OP_SUB, 8'h03, 8'h05, 1'b0);
    alu(csp_pkg::CSP_OP_ADD, 8'hFF, 8'h01, 1'b1);
    rd(9'h003, st);
    repeat (40) begin
      alu(ops[3'($random(seed))], 8'($random(seed)), 8'($random(seed)), 1'($random(seed)));
      alu(ops[3'($random(seed))], 8'($random(seed)), 8'($random(seed)), 1'b0);
      rd(9'h003, st);
    end
    peripheral_irq_gate <= 1'b1;
    global_irq_gate <= 1'b1;
    foreach (bits[i]) begin
      b = 8'h01 << bits[i];
      wr(9'h00C, 8'h00);
      wr(9'h08C, 8'h4F & ~b);
      periph_event <= b;
      idle();
      periph_event <= 8'h00;
      idle();
      idle();
      req(1'b0);
      rd(9'h00C, b);
      wr(9'h08C, b);
      idle();
      idle();
      req(1'b1);
      peripheral_irq_gate <= 1'b0;
      idle();
      idle();
      req(1'b0);
      peripheral_irq_gate <= 1'b1;
      global_irq_gate <= 1'b0;
      idle();
      idle();
      req(1'b0);
      global_irq_gate <= 1'b1;
    end
    idle();
    idle();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule // test_core_status_and_periph_irq_enable
